// File: scsp_pkg.sv
// Constants shared by the serial programming port and its register memory.
// Assumes one 20 MHz clock domain for all logic that uses them.
package scsp_pkg;

  // ********************************************************
  // Register map
  // ********************************************************
  localparam logic [6:0] ADDR_FRAME_OVERHEAD_LENGTH = 7'h49;
  localparam logic [6:0] ADDR_TEMPERATURE_RESULT_A = 7'h7e;
  localparam logic [6:0] ADDR_TEMPERATURE_RESULT_B = 7'h7f;
  localparam logic [7:0] RESET_FRAME_OVERHEAD_LENGTH = 8'h0a;
  localparam logic [7:0] RESET_OTHER = 8'h00;
  localparam int REG_COUNT = 128;

  // ********************************************************
  // Serial frame layout
  // ********************************************************
  localparam logic [4:0] ACCESS_BITS = 5'h10;
  localparam logic [4:0] HEADER_BITS = 5'h08;
  localparam int DIR_BIT = 15;
  localparam logic DIR_WRITE = 1'b1;

  // ********************************************************
  // Timing arithmetic
  // ********************************************************
  localparam logic [7:0] LINE_PERIODS = 8'h81;
  localparam logic [2:0] OVERHEAD_EXTRA = 3'h2;
  // Output mode: 0 = 16, 1 = 8, 2 = 4, 3 = 2 active outputs
  localparam int MODE_WIDTH = 2;

endpackage

// File: scsp_reg_mem.sv
// Programming register memory: 128 bytes, one write port, registered read.
// Assumes the caller pulses clear to restore every default at once.
`timescale 1ns/10ps
module scsp_reg_mem (
  input wire logic clock,
  input wire logic clear,
  input wire logic write_en,
  input wire logic [6:0] write_addr,
  input wire logic [7:0] write_data,
  input wire logic [6:0] read_addr,
  output logic [7:0] read_data,
  output logic [7:0] frame_overhead_length
);

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    logic [scsp_pkg::REG_COUNT-1:0][7:0] mem;
    logic [7:0] rdata;
  } scsp_mem_state_type;

  scsp_mem_state_type state;
  scsp_mem_state_type next_state;

  function automatic logic [7:0] default_of(input logic [6:0] a);
    default_of = (a == scsp_pkg::ADDR_FRAME_OVERHEAD_LENGTH) ?
      scsp_pkg::RESET_FRAME_OVERHEAD_LENGTH : scsp_pkg::RESET_OTHER;
  endfunction

  always_comb begin
    next_state = state;
    next_state.rdata = state.mem[read_addr];
    if (clear) begin
      for (int i = 0; i < scsp_pkg::REG_COUNT; i++) begin
        next_state.mem[i] = default_of(7'(i));
      end
    end else if (write_en) begin
      next_state.mem[write_addr] = write_data;
    end
  end

  always_ff @(posedge clock) begin
    state <= next_state;
  end

  assign read_data = state.rdata;
  assign frame_overhead_length =
    state.mem[scsp_pkg::ADDR_FRAME_OVERHEAD_LENGTH];

endmodule

// File: scsp_port.sv
// Serial programming port of the sensor with frame timing arithmetic.
// Assumes serial pins and reset pin arrive asynchronously and are oversampled.
`timescale 1ns/10ps
module scsp_port #(
  parameter int LINE_COUNT_WIDTH = 12
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic system_reset_low,
  input wire logic serial_clock,
  input wire logic serial_enable,
  input wire logic serial_in,
  input wire logic [15:0] temperature_value,
  input wire logic [scsp_pkg::MODE_WIDTH-1:0] output_mode,
  input wire logic [LINE_COUNT_WIDTH-1:0] line_count,
  output logic serial_out,
  output logic sequencer_reset,
  output logic [16:0] overhead_cycles,
  output logic [10:0] line_cycles,
  output logic [LINE_COUNT_WIDTH+10:0] readout_cycles
);

  // ********************************************************
  // Parameter check
  // ********************************************************
  generate
    if (LINE_COUNT_WIDTH < 1 || LINE_COUNT_WIDTH > 16) begin : g_bad
      $error("LINE_COUNT_WIDTH must lie in 1..16");
    end
  endgenerate

  // ********************************************************
  // Helpers
  // ********************************************************
  // Fewer active outputs stretch a count by 16 over their number
  function automatic logic [10:0] per_outputs(input logic [10:0] v,
    input logic [scsp_pkg::MODE_WIDTH-1:0] m);
    per_outputs = 11'(v << m);
  endfunction

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_s3;
    logic en_s1;
    logic en_s2;
    logic din_s1;
    logic din_s2;
    logic rst_s1;
    logic rst_s2;
    logic rst_s3;
    logic [4:0] bit_count;
    logic [15:0] shift_in;
    logic [7:0] shift_out;
    logic serial_out;
    logic sequencer_reset;
    logic [15:0] temp_hold;
    logic [16:0] overhead_cycles;
    logic [10:0] line_cycles;
    logic [LINE_COUNT_WIDTH+10:0] readout_cycles;
  } scsp_state_type;

  scsp_state_type state;
  scsp_state_type next_state;

  logic mem_clear;
  logic mem_write;
  logic [6:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic [7:0] overhead_length;

  logic sclk_rise;
  logic sclk_fall;
  logic rst_fall;
  logic [6:0] header_addr;
  logic [7:0] read_byte;

  // ********************************************************
  // Register memory
  // ********************************************************
  scsp_reg_mem u_mem (
    .clock(clock),
    .clear(mem_clear),
    .write_en(mem_write),
    .write_addr(state.shift_in[14:8]),
    .write_data(state.shift_in[7:0]),
    .read_addr(mem_raddr),
    .read_data(mem_rdata),
    .frame_overhead_length(overhead_length)
  );

  // ********************************************************
  // Edge detection on the synchronised pins
  // ********************************************************
  // Oversampling: serial clock must stay well below a quarter of clock
  assign sclk_rise = state.sclk_s2 & ~state.sclk_s3;
  assign sclk_fall = ~state.sclk_s2 & state.sclk_s3;
  assign rst_fall = ~state.rst_s2 & state.rst_s3;
  assign mem_clear = srst | rst_fall;
  assign header_addr = {state.shift_in[5:0], state.din_s2};
  // Address is known at the rising edge of the eighth bit
  assign mem_raddr = (state.bit_count == scsp_pkg::HEADER_BITS - 5'h01) ?
    header_addr : state.shift_in[6:0];
  assign mem_write = sclk_fall & state.en_s2 & ~rst_fall &
    (state.bit_count == scsp_pkg::ACCESS_BITS) &
    (state.shift_in[scsp_pkg::DIR_BIT] == scsp_pkg::DIR_WRITE) &
    (state.shift_in[14:8] != scsp_pkg::ADDR_TEMPERATURE_RESULT_A) &
    (state.shift_in[14:8] != scsp_pkg::ADDR_TEMPERATURE_RESULT_B);

  // Temperature bytes come from the snapshot so a burst reads one sample
  always_comb begin
    case (state.shift_in[6:0])
      scsp_pkg::ADDR_TEMPERATURE_RESULT_A: read_byte = state.temp_hold[7:0];
      scsp_pkg::ADDR_TEMPERATURE_RESULT_B: read_byte = state.temp_hold[15:8];
      default: read_byte = mem_rdata;
    endcase
  end

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    next_state = state;
    next_state.sclk_s1 = serial_clock;
    next_state.sclk_s2 = state.sclk_s1;
    next_state.sclk_s3 = state.sclk_s2;
    next_state.en_s1 = serial_enable;
    next_state.en_s2 = state.en_s1;
    next_state.din_s1 = serial_in;
    next_state.din_s2 = state.din_s1;
    next_state.rst_s1 = system_reset_low;
    next_state.rst_s2 = state.rst_s1;
    next_state.rst_s3 = state.rst_s2;
    next_state.sequencer_reset = rst_fall;

    if (rst_fall || !state.en_s2) begin
      // Partial access dropped, output released low
      next_state.bit_count = 5'h00;
      next_state.serial_out = 1'b0;
      // Stale read bits of a cut access must not leak into the next one
      next_state.shift_out = 8'h00;
    end else if (sclk_rise &&
                 state.bit_count < scsp_pkg::ACCESS_BITS) begin
      next_state.shift_in = {state.shift_in[14:0], state.din_s2};
      next_state.bit_count = state.bit_count + 5'h01;
      if (state.bit_count == scsp_pkg::HEADER_BITS - 5'h01 &&
          header_addr == scsp_pkg::ADDR_TEMPERATURE_RESULT_A) begin
        next_state.temp_hold = temperature_value;
      end
    end else if (sclk_fall) begin
      if (state.bit_count == scsp_pkg::HEADER_BITS &&
          state.shift_in[7] != scsp_pkg::DIR_WRITE) begin
        next_state.serial_out = read_byte[7];
        next_state.shift_out = {read_byte[6:0], 1'b0};
      end else if (state.bit_count > scsp_pkg::HEADER_BITS &&
                   state.bit_count < scsp_pkg::ACCESS_BITS) begin
        next_state.serial_out = state.shift_out[7];
        next_state.shift_out = {state.shift_out[6:0], 1'b0};
      end else if (state.bit_count == scsp_pkg::ACCESS_BITS) begin
        // Final falling edge closes the access, next one may follow
        next_state.bit_count = 5'h00;
        next_state.serial_out = 1'b0;
      end
    end

    // Frame timing, recomputed every cycle from the live settings
    next_state.overhead_cycles = 17'((9'(overhead_length) +
      9'(per_outputs(11'(scsp_pkg::OVERHEAD_EXTRA), output_mode))) *
      17'(scsp_pkg::LINE_PERIODS));
    next_state.line_cycles =
      per_outputs(11'(scsp_pkg::LINE_PERIODS), output_mode);
    next_state.readout_cycles = (LINE_COUNT_WIDTH + 11)'(
      state.line_cycles * line_count);

    if (srst) begin
      next_state = '0;
      next_state.rst_s1 = 1'b1;
      next_state.rst_s2 = 1'b1;
      next_state.rst_s3 = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    state <= next_state;
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign serial_out = state.serial_out;
  assign sequencer_reset = state.sequencer_reset;
  assign overhead_cycles = state.overhead_cycles;
  assign line_cycles = state.line_cycles;
  assign readout_cycles = state.readout_cycles;

endmodule

// File: scsp_port_monitor.sv
// Assertion checker for the serial programming port.
// Sees only the port's pins; bound onto every scsp_port instance.
`timescale 1ns/10ps
module scsp_port_monitor #(
  parameter int LINE_COUNT_WIDTH = 12
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic system_reset_low,
  input wire logic serial_clock,
  input wire logic serial_enable,
  input wire logic [scsp_pkg::MODE_WIDTH-1:0] output_mode,
  input wire logic [LINE_COUNT_WIDTH-1:0] line_count,
  input wire logic serial_out,
  input wire logic sequencer_reset,
  input wire logic [16:0] overhead_cycles,
  input wire logic [10:0] line_cycles,
  input wire logic [LINE_COUNT_WIDTH+10:0] readout_cycles
);
  // ****************************************
  // Properties
  // ****************************************
  logic [1:0] up;
  // Timing outputs lag reset release, so they are judged only once settled
  always_ff @(posedge clock) up <= srst ? 2'h0 : up + 2'(up != 2'h3);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_pin_fall;
    $fell(system_reset_low);
  endsequence
  sequence s_high;
    serial_enable && serial_clock;
  endsequence
  a_line_time: assert property (up == 2'h3 |->
    line_cycles == 11'(11'h81 << $past(output_mode))) else $error("line");
  a_readout_time: assert property (up == 2'h3 |->
    readout_cycles == $past(line_cycles) * $past(line_count))
    else $error("readout");
  a_overhead_step: assert property (up == 2'h3 |->
    overhead_cycles % 17'h81 == 17'h0 &&
    overhead_cycles >= (17'h2 << $past(output_mode)) * 17'h81)
    else $error("overhead");
  a_reset_default: assert property (sequencer_reset |-> ##1
    overhead_cycles == (17'h0a + (17'h2 << $past(output_mode))) * 17'h81)
    else $error("default overhead");
  a_reset_pulse: assert property (sequencer_reset |=>
    !sequencer_reset) else $error("pulse");
  a_reset_cause: assert property (s_pin_fall |->
    ##[2:6] sequencer_reset) else $error("no sequencer reset");
  a_idle_out: assert property ((!serial_enable) [*8] |->
    !serial_out) else $error("idle output not low");
  a_out_hold: assert property (s_high ##1 s_high |->
    $stable(serial_out)) else $error("output moved while clock high");
endmodule
bind scsp_port scsp_port_monitor #(.LINE_COUNT_WIDTH(LINE_COUNT_WIDTH))
  scsp_port_monitor_i (.clock(clock), .srst(srst),
  .system_reset_low(system_reset_low), .serial_clock(serial_clock),
  .serial_enable(serial_enable), .output_mode(output_mode),
  .line_count(line_count), .serial_out(serial_out),
  .sequencer_reset(sequencer_reset), .overhead_cycles(overhead_cycles),
  .line_cycles(line_cycles), .readout_cycles(readout_cycles));

// File: scsp_host_model.sv
// Camera host model: drives the serial pins and the sensor reset pin.
// Assumes the testbench calls its tasks from a single process.
`timescale 1ns/10ps
module scsp_host_model (
  input wire logic clock,
  input wire logic serial_out,
  output logic serial_clock,
  output logic serial_enable,
  output logic serial_in,
  output logic system_reset_low
);
  // ****************************************
  // Pin sequences
  // ****************************************
  initial begin
    serial_clock = 1'b0;
    serial_enable = 1'b0;
    serial_in = 1'b0;
    system_reset_low = 1'b0; // Held low through start-up
  end
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic pin_reset();
    system_reset_low = 1'b0;
    step(4); // Several master periods so it is seen
    system_reset_low = 1'b1;
    step(20); // 1 us at 20 MHz before any upload
  endtask
  // Slow serial clock: the port oversamples, far under 48 MHz
  task automatic xfer(input logic [15:0] w, input int n, input bit keep,
    output logic [7:0] rd);
    rd = 8'h00;
    serial_enable = 1'b1;
    step(3); // Enable leads the first sample
    for (int i = 15; i > 15 - n; i--) begin
      serial_in = w[i]; // Direction, address, data, MSB first
      step(5);
      serial_clock = 1'b1;
      rd = {rd[6:0], serial_out}; // Sampled on the rise
      step(i == 0 ? 9 : 4); // Five extra periods after bit 0, the last bit of a full word
      serial_clock = 1'b0;
    end
    step(5);
    if (!keep) begin
      serial_enable = 1'b0;
      serial_in = ~serial_in;
      step(2);
    end
  endtask
endmodule

// File: testbench.sv
// Self-checking bench for the serial programming port.
// Assumes the host model for pin traffic and a 20 MHz clock.
`timescale 1ns/10ps
module testbench;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic serial_clock, serial_enable, serial_in, system_reset_low;
  logic serial_out, sequencer_reset;
  logic [15:0] temperature_value = 16'hbeef;
  logic [1:0] output_mode = 2'h0;
  logic [11:0] line_count = 12'h440;
  logic [16:0] overhead_cycles;
  logic [10:0] line_cycles;
  logic [22:0] readout_cycles;
  logic [7:0] ovh_len = 8'h0a;
  logic [7:0] d;
  int error_cnt = 0;
  int tests_run = 0;
  // Only the master clock is modelled; serializer ratio is the host's
  // Supplies taken as up from time zero, so the clock starts at once
  always #25 clock = ~clock; // 20 MHz, inside both mode limits
  scsp_port scsp_port_i (.clock(clock), .srst(srst),
    .system_reset_low(system_reset_low), .serial_clock(serial_clock),
    .serial_enable(serial_enable), .serial_in(serial_in),
    .temperature_value(temperature_value), .output_mode(output_mode),
    .line_count(line_count), .serial_out(serial_out),
    .sequencer_reset(sequencer_reset), .overhead_cycles(overhead_cycles),
    .line_cycles(line_cycles), .readout_cycles(readout_cycles));
  scsp_host_model scsp_host_model_i (.clock(clock), .serial_out(serial_out),
    .serial_clock(serial_clock), .serial_enable(serial_enable),
    .serial_in(serial_in), .system_reset_low(system_reset_low));
  // ****************************************
  // Tasks and sequence
  // ****************************************
  task automatic check(input logic [22:0] got, input logic [22:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v, input bit k);
    scsp_host_model_i.xfer({1'b1, a, v}, 16, k, d);
  endtask
  task automatic rd(input logic [6:0] a, input bit k, input logic [7:0] e);
    scsp_host_model_i.xfer({1'b0, a, 8'h00}, 16, k, d);
    check(23'(d), 23'(e));
  endtask
  task automatic timing();
    logic [22:0] ln;
    for (int m = 0; m < 4; m++) begin
      output_mode = 2'(m);
      repeat (3) @(posedge clock);
      #1;
      ln = 23'(11'h81 << m);
      check(23'(line_cycles), ln);
      check(readout_cycles, ln * 23'(line_count));
      check(23'(overhead_cycles), (23'(ovh_len) + 23'(2 << m)) * 23'h81);
    end
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge clock);
    #1;
    srst = 1'b0;
    scsp_host_model_i.pin_reset();
    rd(7'h49, 1'b0, 8'h0a);
    timing();
    // No frame request is ever sent: idle, no settling wait
    // Any register group may therefore change here
    wr(7'h49, 8'hff, 1'b1);
    wr(7'h10, 8'h5a, 1'b1);
    wr(7'h7e, 8'h00, 1'b0);
    ovh_len = 8'hff;
    rd(7'h49, 1'b1, 8'hff);
    rd(7'h10, 1'b0, 8'h5a);
    timing();
    rd(7'h7e, 1'b1, 8'hef);
    // A new sample mid-burst must not reach the high byte
    temperature_value = 16'h1234;
    rd(7'h7f, 1'b0, 8'hbe);
    scsp_host_model_i.xfer(16'hc901, 10, 1'b0, d);
    rd(7'h49, 1'b0, 8'hff);
    scsp_host_model_i.pin_reset();
    ovh_len = 8'h0a;
    rd(7'h49, 1'b1, 8'h0a);
    rd(7'h10, 1'b0, 8'h00);
    timing();
    finish_test();
  end
endmodule
